// file: core/rtcs_pkg.sv
// Overview of operation
// R1 - Alarm when running minute and hour match target minute and 5-bit hour.
// R2 - Write-freeze bit freezes the shadow so software can write new time.
// R3 - Year, month, date, weekday, hour, minute, second are set by software.
// R4 - Year 00 and every year divisible by four is a leap year.
// R5 - Seconds and minutes count 00 to 59; hours 00 to 23, 00 is midnight.
// R6 - Weekday 01 to 07 (01 Sunday), date 01-31, month 01-12, year 00-99.
// R7 - Software writes the unlock address before each calendar field write.
// R8 - Six-bit target minute register holds the minute the alarm compares.
// R9 - Read-freeze bit freezes shadow for reads; reads 1 frozen, 0 current.
// R10 - Clearing write-freeze loads the shadow into time; counting resumes.
package rtcs_pkg;

    // Clock and one-second time base
    localparam int CLK_HZ        = 40_000_000;
    localparam int TICK_PERIOD_S = 1;
    localparam int TICK_CYCLES   = CLK_HZ * TICK_PERIOD_S;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_CTRL     = 16'h2890;
    localparam logic [15:0] IDX_SEC      = 16'h2893;
    localparam logic [15:0] IDX_MIN      = 16'h2894;
    localparam logic [15:0] IDX_HR       = 16'h2895;
    localparam logic [15:0] IDX_DAY      = 16'h2896;
    localparam logic [15:0] IDX_DATE     = 16'h2897;
    localparam logic [15:0] IDX_MON      = 16'h2898;
    localparam logic [15:0] IDX_YR       = 16'h2899;
    localparam logic [15:0] IDX_TMIN     = 16'h289e;
    localparam logic [15:0] IDX_THR      = 16'h289f;
    localparam logic [15:0] IDX_UNLOCK   = 16'h20a0;
    localparam logic [15:0] IDX_INT_STAT = 16'h28f0;
    localparam logic [15:0] IDX_INT_EN   = 16'h28f1;
    localparam logic [15:0] IDX_INT_CLR  = 16'h28f2;

    // Field positions
    localparam int CTRL_WR_BIT   = 7;
    localparam int CTRL_RD_BIT   = 6;
    localparam int INT_ALARM_BIT = 0;
    localparam int INT_SEC_BIT   = 1;
    localparam int INT_W         = 2;

    // Values after reset
    localparam logic [5:0] RST_SEC  = 6'h00;
    localparam logic [5:0] RST_MIN  = 6'h00;
    localparam logic [4:0] RST_HR   = 5'h00;
    localparam logic [2:0] RST_DAY  = 3'h1;
    localparam logic [4:0] RST_DATE = 5'h01;
    localparam logic [3:0] RST_MON  = 4'h1;
    localparam logic [7:0] RST_YR   = 8'h00;
    localparam logic [5:0] RST_TMIN = 6'h00;
    localparam logic [4:0] RST_THR  = 5'h00;

    // Field limits
    localparam logic [5:0] SEC_MAX  = 6'h3b;
    localparam logic [4:0] HR_MAX   = 5'h17;
    localparam logic [2:0] DAY_MIN  = 3'h1;
    localparam logic [2:0] DAY_MAX  = 3'h7;
    localparam logic [4:0] DATE_MIN = 5'h01;
    localparam logic [3:0] MON_MIN  = 4'h1;
    localparam logic [3:0] MON_MAX  = 4'hc;
    localparam logic [3:0] MON_FEB  = 4'h2;
    localparam logic [7:0] YR_MAX   = 8'h63;

endpackage

// file: core/rtcs_tick_div.sv
`timescale 1ns/1ps
// One-cycle enable pulse every CYCLES clocks
module rtcs_tick_div #(
    parameter int CYCLES = rtcs_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // Control
    input  wire logic run,
    input  wire logic restart,
    // Pulse out
    output logic      tick
);
    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] countFf;
    logic          tickFf;
    wire           atLast = (countFf == LAST);

    // Held at zero while stopped so a restart gives a full period
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            countFf <= '0;
            tickFf  <= 1'b0;
        end else begin
            countFf <= (restart || !run || atLast) ? '0 : countFf + 1'b1;
            tickFf  <= run && !restart && atLast;
        end
    end

    assign tick = tickFf;
endmodule

// file: core/rtcs_cal_step.sv
`timescale 1ns/1ps
// Calendar value one second later
module rtcs_cal_step (
    // Current time
    input  wire logic [5:0] sec,
    input  wire logic [5:0] min,
    input  wire logic [4:0] hr,
    input  wire logic [2:0] day,
    input  wire logic [4:0] date,
    input  wire logic [3:0] mon,
    input  wire logic [7:0] yr,
    // Advanced time
    output logic      [5:0] nxtSec,
    output logic      [5:0] nxtMin,
    output logic      [4:0] nxtHr,
    output logic      [2:0] nxtDay,
    output logic      [4:0] nxtDate,
    output logic      [3:0] nxtMon,
    output logic      [7:0] nxtYr
);
    // Month length; year kept in binary, so divisible by four is [1:0]==0
    function automatic logic [4:0] monthDays(input logic [3:0] m,
                                             input logic [7:0] y);
        logic leap;
        leap = (y[1:0] == 2'b00); // R4
        if (m == rtcs_pkg::MON_FEB)
            monthDays = leap ? 5'h1d : 5'h1c;
        else if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hb)
            monthDays = 5'h1e;
        else
            monthDays = 5'h1f;
    endfunction

    // Carry chain; >= so a stray out-of-range value still wraps
    wire secWrap  = (sec >= rtcs_pkg::SEC_MAX); // R5
    wire minWrap  = secWrap && (min >= rtcs_pkg::SEC_MAX); // R5
    wire hrWrap   = minWrap && (hr >= rtcs_pkg::HR_MAX); // R5
    wire dateWrap = hrWrap && (date >= monthDays(mon, yr)); // R6
    wire monWrap  = dateWrap && (mon >= rtcs_pkg::MON_MAX); // R6

    // Next values
    assign nxtSec  = secWrap ? 6'h00 : sec + 6'h01;
    assign nxtMin  = minWrap ? 6'h00 : (secWrap ? min + 6'h01 : min);
    assign nxtHr   = hrWrap ? 5'h00 : (minWrap ? hr + 5'h01 : hr);
    assign nxtDay  = !hrWrap ? day :
                     (day >= rtcs_pkg::DAY_MAX) ? rtcs_pkg::DAY_MIN :
                     day + 3'h1; // R6
    assign nxtDate = dateWrap ? rtcs_pkg::DATE_MIN :
                     (hrWrap ? date + 5'h01 : date);
    assign nxtMon  = monWrap ? rtcs_pkg::MON_MIN :
                     (dateWrap ? mon + 4'h1 : mon);
    assign nxtYr   = !monWrap ? yr :
                     (yr >= rtcs_pkg::YR_MAX) ? 8'h00 : yr + 8'h01; // R6
endmodule

// file: core/rtcs_core.sv
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
// Calendar clock with shadow copy, unlock guard, alarm and interrupts
module rtcs_core #(
    parameter int TICK_CYCLES = rtcs_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Avalon-MM slave, byte address
    input  wire logic [17:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Interrupt
    output logic             irq
);
    // Address match, used for every register
    function automatic logic hit(input logic [15:0] a, input logic [15:0] i);
        hit = (a == i);
    endfunction

    localparam int INT_W_L = rtcs_pkg::INT_W;

    logic               waitFf;
    logic [31:0]        readdataFf;
    logic               wrFreezeFf;
    logic               rdFreezeFf;
    logic               armedFf;
    logic [5:0]         secFf;
    logic [5:0]         minFf;
    logic [5:0]         shdSecFf;
    logic [5:0]         shdMinFf;
    logic [5:0]         tgtMinFf;
    logic [4:0]         hrFf;
    logic [4:0]         dateFf;
    logic [4:0]         shdHrFf;
    logic [4:0]         shdDateFf;
    logic [4:0]         tgtHrFf;
    logic [2:0]         dayFf;
    logic [2:0]         shdDayFf;
    logic [3:0]         monFf;
    logic [3:0]         shdMonFf;
    logic [7:0]         yrFf;
    logic [7:0]         shdYrFf;
    logic [INT_W_L-1:0] intStatFf;
    logic [INT_W_L-1:0] intEnFf;
    logic               matchPrevFf;
    logic               irqFf;

    // Bus decode
    wire [15:0] idx    = avs_address[17:2];
    wire        acc    = (avs_read || avs_write) && !waitFf;
    wire        wrAny  = acc && avs_write;
    wire        wrAcc  = wrAny && avs_byteenable[0];
    wire [7:0]  wd     = avs_writedata[7:0];
    wire selCtrl  = hit(idx, rtcs_pkg::IDX_CTRL);
    wire selSec   = hit(idx, rtcs_pkg::IDX_SEC);
    wire selMin   = hit(idx, rtcs_pkg::IDX_MIN);
    wire selHr    = hit(idx, rtcs_pkg::IDX_HR);
    wire selDay   = hit(idx, rtcs_pkg::IDX_DAY);
    wire selDate  = hit(idx, rtcs_pkg::IDX_DATE);
    wire selMon   = hit(idx, rtcs_pkg::IDX_MON);
    wire selYr    = hit(idx, rtcs_pkg::IDX_YR);
    wire selTmin  = hit(idx, rtcs_pkg::IDX_TMIN);
    wire selThr   = hit(idx, rtcs_pkg::IDX_THR);
    wire selUnl   = hit(idx, rtcs_pkg::IDX_UNLOCK);
    wire selStat  = hit(idx, rtcs_pkg::IDX_INT_STAT);
    wire selEn    = hit(idx, rtcs_pkg::IDX_INT_EN);
    wire selClr   = hit(idx, rtcs_pkg::IDX_INT_CLR);
    wire selCal   = selSec || selMin || selHr || selDay || selDate ||
                    selMon || selYr;

    // Write strobes; a calendar write counts only right after an unlock
    wire ctrlWr   = wrAcc && selCtrl;
    wire calWr    = wrAcc && selCal && armedFf; // R7
    wire shdWr    = calWr && wrFreezeFf; // R2
    wire runWr    = calWr && !wrFreezeFf; // R3
    wire commit   = ctrlWr && wrFreezeFf && !wd[rtcs_pkg::CTRL_WR_BIT]; // R10
    wire shdTrack = !wrFreezeFf && !rdFreezeFf; // R9

    // Time base and calendar step
    wire       tick;
    wire       stepEn = tick && !wrFreezeFf; // R2
    wire [5:0] stSec, stMin;
    wire [4:0] stHr, stDate;
    wire [2:0] stDay;
    wire [3:0] stMon;
    wire [7:0] stYr;

    rtcs_tick_div #(
        .CYCLES (TICK_CYCLES)
    ) u_div (
        .clock   (clock),
        .reset_n (reset_n),
        .run     (!wrFreezeFf),
        .restart (commit),
        .tick    (tick)
    );

    rtcs_cal_step u_step (
        .sec     (secFf),
        .min     (minFf),
        .hr      (hrFf),
        .day     (dayFf),
        .date    (dateFf),
        .mon     (monFf),
        .yr      (yrFf),
        .nxtSec  (stSec),
        .nxtMin  (stMin),
        .nxtHr   (stHr),
        .nxtDay  (stDay),
        .nxtDate (stDate),
        .nxtMon  (stMon),
        .nxtYr   (stYr)
    );

    // Alarm and interrupt terms; set wins over clear
    wire match = (minFf == tgtMinFf) && (hrFf == tgtHrFf); // R1
    wire alarmEv = match && !matchPrevFf; // R1
    wire [INT_W_L-1:0] events = {stepEn, alarmEv};
    wire [INT_W_L-1:0] clrMask = (wrAcc && selClr) ? wd[INT_W_L-1:0] : '0;
    wire [INT_W_L-1:0] nxt_intStat = (intStatFf & ~clrMask) | events;

    // Read mux; unmapped indices read zero
    wire [31:0] rdMux =
        ({32{selCtrl}} & {24'h0, wrFreezeFf, rdFreezeFf, 6'h00}) | // R9
        ({32{selSec}}  & {26'h0, shdSecFf})  |
        ({32{selMin}}  & {26'h0, shdMinFf})  |
        ({32{selHr}}   & {27'h0, shdHrFf})   |
        ({32{selDay}}  & {29'h0, shdDayFf})  |
        ({32{selDate}} & {27'h0, shdDateFf}) |
        ({32{selMon}}  & {28'h0, shdMonFf})  |
        ({32{selYr}}   & {24'h0, shdYrFf})   |
        ({32{selTmin}} & {26'h0, tgtMinFf})  |
        ({32{selThr}}  & {27'h0, tgtHrFf})   |
        ({32{selStat}} & {30'h0, intStatFf}) |
        ({32{selEn}}   & {30'h0, intEnFf});

    // Bus handshake: one wait cycle, then a single accept cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            waitFf     <= 1'b1;
            readdataFf <= 32'h0000_0000;
        end else begin
            waitFf <= !((avs_read || avs_write) && waitFf);
            if (avs_read && waitFf)
                readdataFf <= rdMux;
        end
    end

    // Control bits and unlock arm; any other write disarms
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wrFreezeFf <= 1'b0;
            rdFreezeFf <= 1'b0;
            armedFf    <= 1'b0;
        end else begin
            if (ctrlWr) begin
                wrFreezeFf <= wd[rtcs_pkg::CTRL_WR_BIT]; // R2
                rdFreezeFf <= wd[rtcs_pkg::CTRL_RD_BIT]; // R9
            end
            if (wrAny)
                armedFf <= selUnl; // R7
        end
    end

    // Alarm targets
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tgtMinFf <= rtcs_pkg::RST_TMIN;
            tgtHrFf  <= rtcs_pkg::RST_THR;
        end else begin
            if (wrAcc && selTmin)
                tgtMinFf <= wd[5:0]; // R8
            if (wrAcc && selThr)
                tgtHrFf <= wd[4:0]; // R1
        end
    end

    // Running counters: commit, then step, and a direct write overrides
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            secFf  <= rtcs_pkg::RST_SEC;
            minFf  <= rtcs_pkg::RST_MIN;
            hrFf   <= rtcs_pkg::RST_HR;
            dayFf  <= rtcs_pkg::RST_DAY;
            dateFf <= rtcs_pkg::RST_DATE;
            monFf  <= rtcs_pkg::RST_MON;
            yrFf   <= rtcs_pkg::RST_YR;
        end else if (commit) begin // R10
            secFf  <= shdSecFf;
            minFf  <= shdMinFf;
            hrFf   <= shdHrFf;
            dayFf  <= shdDayFf;
            dateFf <= shdDateFf;
            monFf  <= shdMonFf;
            yrFf   <= shdYrFf;
        end else begin
            if (stepEn) begin // R5
                secFf  <= stSec;
                minFf  <= stMin;
                hrFf   <= stHr;
                dayFf  <= stDay;
                dateFf <= stDate;
                monFf  <= stMon;
                yrFf   <= stYr;
            end
            if (runWr && selSec)  secFf  <= wd[5:0]; // R3
            if (runWr && selMin)  minFf  <= wd[5:0];
            if (runWr && selHr)   hrFf   <= wd[4:0];
            if (runWr && selDay)  dayFf  <= wd[2:0];
            if (runWr && selDate) dateFf <= wd[4:0];
            if (runWr && selMon)  monFf  <= wd[3:0];
            if (runWr && selYr)   yrFf   <= wd[7:0];
        end
    end

    // Shadow copy: tracks while neither freeze is set
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shdSecFf  <= rtcs_pkg::RST_SEC;
            shdMinFf  <= rtcs_pkg::RST_MIN;
            shdHrFf   <= rtcs_pkg::RST_HR;
            shdDayFf  <= rtcs_pkg::RST_DAY;
            shdDateFf <= rtcs_pkg::RST_DATE;
            shdMonFf  <= rtcs_pkg::RST_MON;
            shdYrFf   <= rtcs_pkg::RST_YR;
        end else if (shdTrack) begin // R9
            shdSecFf  <= secFf;
            shdMinFf  <= minFf;
            shdHrFf   <= hrFf;
            shdDayFf  <= dayFf;
            shdDateFf <= dateFf;
            shdMonFf  <= monFf;
            shdYrFf   <= yrFf;
        end else begin
            if (shdWr && selSec)  shdSecFf  <= wd[5:0]; // R2
            if (shdWr && selMin)  shdMinFf  <= wd[5:0];
            if (shdWr && selHr)   shdHrFf   <= wd[4:0];
            if (shdWr && selDay)  shdDayFf  <= wd[2:0];
            if (shdWr && selDate) shdDateFf <= wd[4:0];
            if (shdWr && selMon)  shdMonFf  <= wd[3:0];
            if (shdWr && selYr)   shdYrFf   <= wd[7:0];
        end
    end

    // Interrupts; match history starts high so reset time gives no alarm
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            matchPrevFf <= 1'b1;
            intStatFf   <= '0;
            intEnFf     <= '0;
            irqFf       <= 1'b0;
        end else begin
            matchPrevFf <= match;
            intStatFf   <= nxt_intStat; // R1
            if (wrAcc && selEn)
                intEnFf <= wd[INT_W_L-1:0];
            irqFf <= |(nxt_intStat & intEnFf);
        end
    end

    assign avs_readdata    = readdataFf;
    assign avs_waitrequest = waitFf;
    assign irq             = irqFf;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    wire endOfDay = (secFf == rtcs_pkg::SEC_MAX) &&
                    (minFf == rtcs_pkg::SEC_MAX) && (hrFf == rtcs_pkg::HR_MAX);
    wire quiet = !wrAny;

    a_alarm_sets_status: assert property ( // R1
        (match && !matchPrevFf) |=> intStatFf[rtcs_pkg::INT_ALARM_BIT])
        else $error("alarm match did not set status");
    a_freeze_holds_time: assert property ( // R2
        (wrFreezeFf && quiet) |=> ($stable(secFf) && $stable(dateFf)))
        else $error("running time moved while write-frozen");
    a_direct_write_load: assert property ( // R3
        (runWr && selMin) |=> (minFf == $past(wd[5:0])))
        else $error("minute write not taken");
    a_leap_day_added: assert property ( // R4
        (stepEn && quiet && endOfDay && monFf == rtcs_pkg::MON_FEB &&
         dateFf == 5'h1c && yrFf[1:0] == 2'b00) |=> (dateFf == 5'h1d))
        else $error("leap year lost 29th");
    a_midnight_wrap: assert property ( // R5
        (stepEn && quiet && endOfDay) |=>
        (hrFf == 5'h00 && minFf == 6'h00 && secFf == 6'h00))
        else $error("midnight wrap wrong");
    a_weekday_wrap: assert property ( // R6
        (stepEn && quiet && endOfDay && dayFf == rtcs_pkg::DAY_MAX) |=>
        (dayFf == rtcs_pkg::DAY_MIN))
        else $error("weekday did not return to 1");
    a_unlock_guard: assert property ( // R7
        (wrAcc && selSec && !armedFf && wrFreezeFf) |=> $stable(shdSecFf))
        else $error("calendar write taken without unlock");
    a_target_minute: assert property ( // R8
        (wrAcc && selTmin) |=> (tgtMinFf == $past(wd[5:0])))
        else $error("target minute not stored");
    a_read_freeze_hold: assert property ( // R9
        (rdFreezeFf && !wrFreezeFf) |=> $stable(shdHrFf))
        else $error("shadow moved while read-frozen");
    a_commit_loads: assert property ( // R10
        $fell(wrFreezeFf) |-> (secFf == $past(shdSecFf) &&
                               yrFf == $past(shdYrFf)))
        else $error("shadow not committed on release");
    a_bus_one_wait: assert property (
        ((avs_read || avs_write) && waitFf) |=> !waitFf ##1 waitFf)
        else $error("waitrequest timing wrong");

    // Software polls these, so they must not move between events
    a_readdata_holds: assert property (
        !(avs_read && waitFf) |=> $stable(readdataFf))
        else $error("read data moved without a read");
    a_ctrl_readback: assert property ( // R9
        (avs_read && waitFf && selCtrl) |=>
        (readdataFf[7:6] == $past({wrFreezeFf, rdFreezeFf})))
        else $error("freeze bits read back wrong");
    a_unlock_disarm: assert property (
        (wrAny && !selUnl) |=> !armedFf)
        else $error("unlock stayed armed after another write");
    a_second_step: assert property ( // R5
        (stepEn && quiet && secFf < rtcs_pkg::SEC_MAX) |=>
        (secFf == $past(secFf) + 6'h01))
        else $error("seconds did not advance");
    a_alarm_only_source: assert property ( // R1
        (!intStatFf[rtcs_pkg::INT_ALARM_BIT] && !(match && !matchPrevFf))
        |=> !intStatFf[rtcs_pkg::INT_ALARM_BIT])
        else $error("alarm status set without a match");
    a_clear_drops_alarm: assert property (
        (wrAcc && selClr && wd[rtcs_pkg::INT_ALARM_BIT] && !alarmEv) |=>
        !intStatFf[rtcs_pkg::INT_ALARM_BIT])
        else $error("alarm status not cleared");
    a_irq_level: assert property (
        irqFf == |(intStatFf & $past(intEnFf)))
        else $error("interrupt line does not follow status and enable");

    c_alarm_fires:   cover property (alarmEv);
    c_commit_seen:   cover property (commit);
    c_year_rollover: cover property (stepEn && endOfDay && yrFf == 8'h63);
    c_irq_raised:    cover property ($rose(irqFf));
    c_read_frozen:   cover property (rdFreezeFf && tick);
endmodule

// file: tb/rtc_calendar_shadow_alarm_bench.sv
`timescale 1ns/1ps
module rtc_calendar_shadow_alarm_bench;
    // Short second so rollovers happen within a few dozen cycles
    localparam int TICKS = 20;

    // Clock, reset and bus drive
    logic        clock;
    logic        reset_n;
    logic [17:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    // Bookkeeping
    int          mismatches;
    int          checksDone;
    logic [31:0] rdVal;

    rtcs_core #(.TICK_CYCLES(TICKS)) i_dut (
        .clock           (clock),
        .reset_n         (reset_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .irq             (irq)
    );

    // 40 MHz clock
    always #12.5 clock = ~clock;

    task automatic complete_run();
        if (mismatches == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One access, held until waitrequest is sampled low at an edge
    task automatic bus_access(input logic wr, input logic [15:0] idx,
                              input logic [31:0] data);
        int waitCount;
        waitCount = 0;
        @(posedge clock);
        avs_address   <= {idx, 2'b00};
        avs_writedata <= data;
        avs_write     <= wr;
        avs_read      <= ~wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) begin
            waitCount++;
            @(posedge clock);
        end
        rdVal = avs_readdata;
        check("bus wait cycles", waitCount, 32'h1);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    // Freeze, unlock and load all fields, release, let one second pass,
    // then freeze the shadow for reading
    task automatic set_time(input logic [7:0] f [7]);
        bus_access(1'b1, rtcs_pkg::IDX_CTRL, 32'h80);
        for (int i = 0; i < 7; i++) begin
            bus_access(1'b1, rtcs_pkg::IDX_UNLOCK, 32'h00);
            bus_access(1'b1, rtcs_pkg::IDX_SEC + 16'(i), {24'h0, f[i]});
        end
        bus_access(1'b1, rtcs_pkg::IDX_CTRL, 32'h00);
        repeat (TICKS + 10) @(posedge clock);
        bus_access(1'b1, rtcs_pkg::IDX_CTRL, 32'h40);
    endtask

    task automatic expect_time(input logic [7:0] f [7]);
        for (int i = 0; i < 7; i++) begin
            bus_access(1'b0, rtcs_pkg::IDX_SEC + 16'(i), 32'h0);
            check("calendar field", rdVal, {24'h0, f[i]});
        end
    endtask

    // Reset values, read freeze flag and frozen shadow
    task automatic test_reset_values();
        bus_access(1'b0, rtcs_pkg::IDX_CTRL, 32'h0);
        check("ctrl after reset", rdVal, 32'h0);
        bus_access(1'b1, rtcs_pkg::IDX_CTRL, 32'h40);
        bus_access(1'b0, rtcs_pkg::IDX_CTRL, 32'h0);
        check("read freeze flag", rdVal, 32'h40);
        expect_time('{8'h0, 8'h0, 8'h0, 8'h1, 8'h1, 8'h1, 8'h0});
        repeat (TICKS + 5) @(posedge clock);
        bus_access(1'b0, rtcs_pkg::IDX_SEC, 32'h0);
        check("frozen seconds", rdVal, 32'h0);
        bus_access(1'b1, rtcs_pkg::IDX_CTRL, 32'h00);
        bus_access(1'b0, rtcs_pkg::IDX_CTRL, 32'h0);
        check("shadow current flag", rdVal, 32'h0);
    endtask

    // Calendar writes only land right after an unlock write
    task automatic test_unlock();
        bus_access(1'b1, rtcs_pkg::IDX_CTRL, 32'h80);
        bus_access(1'b1, rtcs_pkg::IDX_UNLOCK, 32'h00);
        bus_access(1'b1, rtcs_pkg::IDX_SEC, 32'h22);
        bus_access(1'b0, rtcs_pkg::IDX_SEC, 32'h0);
        check("unlocked write", rdVal, 32'h22);
        bus_access(1'b1, rtcs_pkg::IDX_SEC, 32'h11);
        bus_access(1'b0, rtcs_pkg::IDX_SEC, 32'h0);
        check("write without unlock", rdVal, 32'h22);
        // An unrelated write between unlock and field disarms it
        bus_access(1'b1, rtcs_pkg::IDX_UNLOCK, 32'h00);
        bus_access(1'b1, rtcs_pkg::IDX_TMIN, 32'h00);
        bus_access(1'b1, rtcs_pkg::IDX_SEC, 32'h11);
        bus_access(1'b0, rtcs_pkg::IDX_SEC, 32'h0);
        check("disarmed write", rdVal, 32'h22);
        // A write with byte lane 0 off is dropped and still disarms
        bus_access(1'b1, rtcs_pkg::IDX_UNLOCK, 32'h00);
        avs_byteenable <= 4'he;
        bus_access(1'b1, rtcs_pkg::IDX_SEC, 32'h33);
        avs_byteenable <= 4'hf;
        bus_access(1'b1, rtcs_pkg::IDX_SEC, 32'h33);
        bus_access(1'b0, rtcs_pkg::IDX_SEC, 32'h0);
        check("lane off write", rdVal, 32'h22);
    endtask

    // Every field wraps at its top value in one second
    task automatic test_rollover();
        set_time('{8'h3b, 8'h3b, 8'h17, 8'h7, 8'h1f, 8'h0c, 8'h63});
        expect_time('{8'h0, 8'h0, 8'h0, 8'h1, 8'h1, 8'h1, 8'h0});
    endtask

    // End of February in leap and common years
    task automatic test_leap();
        logic [7:0] yr   [4] = '{8'h00, 8'h04, 8'h03, 8'h04};
        logic [7:0] dIn  [4] = '{8'h1c, 8'h1c, 8'h1c, 8'h1d};
        logic [7:0] dOut [4] = '{8'h1d, 8'h1d, 8'h01, 8'h01};
        logic [7:0] mOut [4] = '{8'h02, 8'h02, 8'h03, 8'h03};
        for (int i = 0; i < 4; i++) begin
            set_time('{8'h3b, 8'h3b, 8'h17, 8'h2, dIn[i], 8'h02, yr[i]});
            expect_time('{8'h0, 8'h0, 8'h0, 8'h3,
                          dOut[i], mOut[i], yr[i]});
        end
    endtask

    // Alarm raised, masked, enabled, cleared, and not raised on hour miss
    task automatic test_alarm();
        bus_access(1'b1, rtcs_pkg::IDX_TMIN, 32'h05);
        bus_access(1'b1, rtcs_pkg::IDX_THR, 32'h03);
        bus_access(1'b0, rtcs_pkg::IDX_TMIN, 32'h0);
        check("target minute", rdVal, 32'h05);
        bus_access(1'b0, rtcs_pkg::IDX_THR, 32'h0);
        check("target hour", rdVal, 32'h03);
        bus_access(1'b1, rtcs_pkg::IDX_INT_EN, 32'h00);
        bus_access(1'b1, rtcs_pkg::IDX_INT_CLR, 32'h03);
        set_time('{8'h3b, 8'h04, 8'h03, 8'h1, 8'h1, 8'h1, 8'h0});
        bus_access(1'b0, rtcs_pkg::IDX_INT_STAT, 32'h0);
        check("alarm status", rdVal & 32'h1, 32'h1);
        check("masked irq", {31'h0, irq}, 32'h0);
        bus_access(1'b1, rtcs_pkg::IDX_INT_EN, 32'h01);
        repeat (2) @(posedge clock);
        check("enabled irq", {31'h0, irq}, 32'h1);
        bus_access(1'b1, rtcs_pkg::IDX_INT_CLR, 32'h01);
        repeat (2) @(posedge clock);
        check("cleared irq", {31'h0, irq}, 32'h0);
        set_time('{8'h3b, 8'h04, 8'h02, 8'h1, 8'h1, 8'h1, 8'h0});
        check("hour mismatch irq", {31'h0, irq}, 32'h0);
    endtask

    // Unmapped place reads zero and keeps nothing
    task automatic test_unmapped();
        bus_access(1'b1, 16'h2891, 32'h5a);
        bus_access(1'b0, 16'h2891, 32'h0);
        check("unmapped read", rdVal, 32'h0);
    endtask

    // Watchdog; whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        complete_run();
    end

    // Main sequence
    initial begin
        clock          = 1'b0;
        reset_n        = 1'b0;
        avs_address    = 18'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hf;
        mismatches     = 0;
        checksDone     = 0;
        repeat (5) @(posedge clock);
        check("waitrequest in reset", {31'h0, avs_waitrequest}, 32'h1);
        check("irq in reset", {31'h0, irq}, 32'h0);
        reset_n <= 1'b1;
        test_reset_values();
        test_unlock();
        test_rollover();
        test_leap();
        test_alarm();
        test_unmapped();
        complete_run();
    end
endmodule
